// ===== sts_pkg.sv
// package: constants, types and register map of the scan trigger sequencer
package sts_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  // one tick per millisecond drives all delay counters
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  // longest timer / extra delay: 999999.999 s in ms
  localparam logic [31:0] TIMER_MAX_MS = 32'h3B9A_C9FF;
  // manual settle max: 99 h 99 min 99.999 s in ms
  localparam logic [31:0] SETTLE_MAX_MS = 32'h159A_653F;
  localparam logic [31:0] AVG_DELAY_RST_MS = 32'h0000_01F4;
  localparam logic [31:0] AUTO_DELAY_MS = 32'h0000_0001;
  localparam logic [31:0] COUNT_RST = 32'h0000_000A;
  localparam int LIST_DEPTH = 16;
  localparam int LIST_AW = 4;
  localparam logic [LIST_AW:0] LIST_LEN_RST = 5'h01;

  // byte addresses, aligned words
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_TIMER = 8'h0C;
  localparam logic [7:0] ADDR_SETTLE = 8'h10;
  localparam logic [7:0] ADDR_AVG = 8'h14;
  localparam logic [7:0] ADDR_LEN = 8'h18;
  localparam logic [7:0] ADDR_LIST = 8'h40;

  // control field positions
  localparam int CTRL_STEP_GO = 0;
  localparam int CTRL_SCAN_GO = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_SRC_LO = 3;
  localparam int CTRL_SRC_HI = 4;
  localparam int CTRL_MANUAL = 5;
  localparam int CTRL_AVG = 6;
  localparam int CTRL_FILT = 7;
  localparam int CTRL_ENDLESS = 8;
  localparam int CTRL_KEY = 9;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    STS_SRC_IMMEDIATE = 2'b00,
    STS_SRC_TIMER = 2'b01,
    STS_SRC_EXTERNAL = 2'b10
  } sts_src_t;

  typedef enum logic [3:0] {
    STS_IDLE = 4'b0000,
    STS_OPEN = 4'b0001,
    STS_BREAK = 4'b0010,
    STS_CLOSE = 4'b0011,
    STS_SOURCE = 4'b0100,
    STS_DELAY = 4'b0101,
    STS_AVG = 4'b0110,
    STS_MEAS = 4'b0111,
    STS_STORE = 4'b1000
  } sts_state_t;
endpackage : sts_pkg

// ===== sts_down_timer.sv
// file: millisecond down counter used for timer and delay stages
`timescale 1ns/1ps
module sts_down_timer
  import sts_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic tick, // 1 ms enable pulse
  input wire logic load, // start counting
  input wire logic [31:0] load_ms, // length in ms
  output logic done // high when expired
);
  logic [31:0] remain;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remain <= 32'h0000_0000;
    end
    else if (load)
    begin
      remain <= load_ms;
    end
    else if (tick && remain != 32'h0000_0000)
    begin
      remain <= remain - 32'h0000_0001;
    end
  end
  assign done = (remain == 32'h0000_0000) && !load;
endmodule : sts_down_timer

// ===== sts_sequencer.sv
// file: scan trigger sequencer top with its AXI4-Lite register slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - start leaves idle, closes first, waits source
// - step: pulse out, swap channel, rewait
// - scan: swap channels freely, pulse at end
// - each further pass waits fresh trigger
// - scan done: idle with first channel closed
// - idle reaches control source only after open, break and close
// - three sources, block until event
// - immediate source passes at once
// - timer source bypasses wait first pass
// - later passes wait max(timer, delay)
// - timer to 999999.999 s, reset at end
// - timer spacing per channel or per pass
// - external or key trigger advances once
// - settle delay auto or manual, bounded
// - averaging adds extra delay after settle
// - measure, plus repeat filter when enabled
// - step count from reading count
// - step leaves last closed, resumes next
// - endless count runs until stopped
// - scan sample count equals list length
// - passes equal count over length, rounded up
// - channel id: slot digit, two channel digits
module sts_sequencer
  import sts_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axil_awaddr, // write address
  input wire logic s_axil_awvalid, // write address valid
  output logic s_axil_awready, // write address ready
  input wire logic [31:0] s_axil_wdata, // write data
  input wire logic [3:0] s_axil_wstrb, // write strobes
  input wire logic s_axil_wvalid, // write data valid
  output logic s_axil_wready, // write data ready
  output logic [1:0] s_axil_bresp, // write response
  output logic s_axil_bvalid, // write response valid
  input wire logic s_axil_bready, // write response ready
  input wire logic [7:0] s_axil_araddr, // read address
  input wire logic s_axil_arvalid, // read address valid
  output logic s_axil_arready, // read address ready
  output logic [31:0] s_axil_rdata, // read data
  output logic [1:0] s_axil_rresp, // read response
  output logic s_axil_rvalid, // read data valid
  input wire logic s_axil_rready, // read data ready
  input wire logic ext_trigger_in, // external trigger pulse
  output logic trigger_out, // output trigger pulse
  output logic [11:0] relay_close_id, // channel to close, bcd
  output logic relay_close, // close request, level
  input wire logic relay_open_ack, // all relays open
  output logic meas_start, // measurement start pulse
  output logic meas_filter, // repeat filter with measurement
  input wire logic meas_done // reading stored pulse
);
  import sts_pkg::*;

  sts_state_t state;
  logic [31:0] ctrl;
  logic [31:0] rd_count;
  logic [31:0] timer_ms;
  logic [31:0] settle_ms;
  logic [31:0] avg_ms;
  logic [LIST_AW:0] list_len;
  logic [11:0] list_mem [LIST_DEPTH];
  logic [LIST_AW-1:0] ptr;
  logic [LIST_AW:0] samples_left;
  logic [31:0] manual_trigger_key_left;
  logic first_pass;
  logic scan_mode;
  logic key_pulse;
  logic step_go;
  logic scan_go;
  logic stop_req;
  logic [31:0] tick_cnt;
  logic tick;
  logic wait_load;
  logic [31:0] wait_ms;
  logic wait_done;
  logic avg_load;
  logic avg_done;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] next_wval;
  logic [31:0] settle_eff;
  logic [31:0] passes;
  sts_src_t src;

  assign src = sts_src_t'(ctrl[CTRL_SRC_HI:CTRL_SRC_LO]);

  // write channel: address and data taken in either order
  assign s_axil_awready = !aw_held && !s_axil_bvalid;
  assign s_axil_wready = !w_held && !s_axil_bvalid;
  assign wr_fire = aw_held && w_held && !s_axil_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axil_awvalid && s_axil_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axil_wdata;
        w_strb <= s_axil_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axil_bvalid <= 1'b1;
        if (aw_addr <= ADDR_LEN || (aw_addr >= ADDR_LIST &&
            aw_addr < ADDR_LIST + 8'(LIST_DEPTH * 4)))
          s_axil_bresp <= RESP_OKAY;
        else
          s_axil_bresp <= RESP_SLVERR;
      end
      else if (s_axil_bvalid && s_axil_bready)
      begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  // strobes see only the bytes written now, not the stored control word
  assign next_wval = merge(32'h0000_0000, w_data, w_strb);

  // control strobes are self clearing; stored bits steer the sequencer
  always_ff @(posedge aclk)
  begin
    step_go <= 1'b0;
    scan_go <= 1'b0;
    stop_req <= 1'b0;
    key_pulse <= 1'b0;
    if (!aresetn)
    begin
      ctrl <= 32'h0000_0000;
      rd_count <= COUNT_RST;
      timer_ms <= 32'h0000_0000;
      settle_ms <= 32'h0000_0000;
      avg_ms <= AVG_DELAY_RST_MS;
      list_len <= LIST_LEN_RST;
    end
    else if (wr_fire)
    begin
      if (aw_addr == ADDR_CTRL)
      begin
        ctrl <= merge(ctrl, w_data, w_strb);
        step_go <= next_wval[CTRL_STEP_GO];
        scan_go <= next_wval[CTRL_SCAN_GO];
        stop_req <= next_wval[CTRL_STOP];
        key_pulse <= next_wval[CTRL_KEY];
      end
      else if (aw_addr == ADDR_COUNT)
        rd_count <= merge(rd_count, w_data, w_strb);
      else if (aw_addr == ADDR_TIMER)
        timer_ms <= (w_data > TIMER_MAX_MS) ? TIMER_MAX_MS : w_data;
      else if (aw_addr == ADDR_SETTLE)
        settle_ms <= (w_data > SETTLE_MAX_MS) ? SETTLE_MAX_MS : w_data;
      else if (aw_addr == ADDR_AVG)
        avg_ms <= (w_data > TIMER_MAX_MS) ? TIMER_MAX_MS : w_data;
      else if (aw_addr == ADDR_LEN)
        list_len <= (w_data[LIST_AW:0] == '0) ? LIST_LEN_RST :
                    (w_data[LIST_AW:0] > 5'(LIST_DEPTH)) ? 5'(LIST_DEPTH) :
                    w_data[LIST_AW:0];
    end
  end

  // list entries hold slot digit and two channel digits
  always_ff @(posedge aclk)
  begin
    if (wr_fire && aw_addr >= ADDR_LIST &&
        aw_addr < ADDR_LIST + 8'(LIST_DEPTH * 4))
      list_mem[aw_addr[LIST_AW+1:2]] <= w_data[11:0];
  end

  // read channel
  assign s_axil_arready = !s_axil_rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= RESP_OKAY;
    end
    else if (s_axil_arvalid && s_axil_arready)
    begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp <= RESP_OKAY;
      if (s_axil_araddr == ADDR_CTRL)
        s_axil_rdata <= ctrl & 32'h0000_01F8;
      else if (s_axil_araddr == ADDR_STATUS)
        s_axil_rdata <= {manual_trigger_key_left[15:0], 3'b000, samples_left,
                         ptr, state};
      else if (s_axil_araddr == ADDR_COUNT)
        s_axil_rdata <= rd_count;
      else if (s_axil_araddr == ADDR_TIMER)
        s_axil_rdata <= timer_ms;
      else if (s_axil_araddr == ADDR_SETTLE)
        s_axil_rdata <= settle_ms;
      else if (s_axil_araddr == ADDR_AVG)
        s_axil_rdata <= avg_ms;
      else if (s_axil_araddr == ADDR_LEN)
        s_axil_rdata <= 32'(list_len);
      else if (s_axil_araddr >= ADDR_LIST &&
               s_axil_araddr < ADDR_LIST + 8'(LIST_DEPTH * 4))
        s_axil_rdata <= 32'(list_mem[s_axil_araddr[LIST_AW+1:2]]);
      else
      begin
        s_axil_rdata <= 32'h0000_0000;
        s_axil_rresp <= RESP_SLVERR;
      end
    end
    else if (s_axil_rvalid && s_axil_rready)
    begin
      s_axil_rvalid <= 1'b0;
    end
  end

  // millisecond tick from one divider
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick_cnt == TICK_LAST)
      tick_cnt <= 32'h0000_0000;
    else
      tick_cnt <= tick_cnt + 32'h0000_0001;
  end
  assign tick = (tick_cnt == TICK_LAST);

  // auto delay is fixed, manual is user value
  assign settle_eff = ctrl[CTRL_MANUAL] ? settle_ms : AUTO_DELAY_MS;

  sts_down_timer u_wait (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .load(wait_load),
    .load_ms(wait_ms),
    .done(wait_done)
  );

  sts_down_timer u_avg (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .load(avg_load),
    .load_ms(avg_ms),
    .done(avg_done)
  );

  assign passes = (rd_count + 32'(list_len) - 32'h0000_0001) /
                  32'(list_len);

  function automatic logic [LIST_AW-1:0] wrap(input logic [LIST_AW-1:0] p,
                                              input logic [LIST_AW:0] n);
    return ((5'(p) + 5'h01) >= n) ? '0 : p + 1'b1;
  endfunction : wrap

  always_ff @(posedge aclk)
  begin
    wait_load <= 1'b0;
    avg_load <= 1'b0;
    meas_start <= 1'b0;
    trigger_out <= 1'b0;
    if (!aresetn)
    begin
      state <= STS_IDLE;
      ptr <= '0;
      samples_left <= '0;
      manual_trigger_key_left <= 32'h0000_0000;
      first_pass <= 1'b1;
      scan_mode <= 1'b0;
      relay_close <= 1'b0;
      relay_close_id <= 12'h000;
      meas_filter <= 1'b0;
      wait_ms <= 32'h0000_0000;
    end
    else if (stop_req && state != STS_IDLE)
    begin
      state <= STS_IDLE;
      first_pass <= 1'b1;
    end
    else
    begin
      case (state)
        STS_IDLE:
        begin
          if (step_go || scan_go)
          begin
            scan_mode <= scan_go;
            first_pass <= 1'b1;
            manual_trigger_key_left <= scan_go ? passes : rd_count;
            samples_left <= list_len;
            ptr <= scan_go ? '0 : ptr;
            state <= STS_OPEN;
          end
        end
        STS_OPEN:
        begin
          relay_close <= 1'b0;
          state <= STS_BREAK;
        end
        STS_BREAK:
        begin
          if (relay_open_ack)
            state <= STS_CLOSE;
        end
        STS_CLOSE:
        begin
          relay_close <= 1'b1;
          relay_close_id <= list_mem[ptr];
          // inside a pass, skip the source
          if (scan_mode && samples_left != 5'(list_len))
          begin
            wait_ms <= settle_eff;
            wait_load <= 1'b1;
            state <= STS_DELAY;
          end
          else
            state <= STS_SOURCE;
        end
        STS_SOURCE:
        begin
          if (src != STS_SRC_EXTERNAL || ext_trigger_in || key_pulse)
          begin
            // later: larger of timer and delay
            // source reached per channel or pass
            if (src == STS_SRC_TIMER && !first_pass &&
                timer_ms > settle_eff)
              wait_ms <= timer_ms;
            else
              wait_ms <= settle_eff;
            wait_load <= 1'b1;
            first_pass <= 1'b0;
            state <= STS_DELAY;
          end
        end
        STS_DELAY:
        begin
          if (wait_done)
          begin
            avg_load <= ctrl[CTRL_AVG];
            state <= ctrl[CTRL_AVG] ? STS_AVG : STS_MEAS;
            meas_start <= !ctrl[CTRL_AVG];
            meas_filter <= ctrl[CTRL_FILT];
          end
        end
        STS_AVG:
        begin
          if (avg_done && !avg_load)
          begin
            meas_start <= 1'b1;
            state <= STS_MEAS;
          end
        end
        STS_MEAS:
        begin
          if (meas_done)
            state <= STS_STORE;
        end
        default:
        begin
          ptr <= wrap(ptr, list_len);
          state <= STS_OPEN;
          if (!scan_mode)
          begin
            trigger_out <= 1'b1;
            if (!ctrl[CTRL_ENDLESS])
              manual_trigger_key_left <= manual_trigger_key_left - 32'h0000_0001;
            if (!ctrl[CTRL_ENDLESS] && manual_trigger_key_left <= 32'h0000_0001)
            begin
              ptr <= wrap(ptr, list_len);
              state <= STS_IDLE;
            end
          end
          else if (samples_left <= 5'h01)
          begin
            trigger_out <= 1'b1;
            samples_left <= list_len;
            ptr <= '0;
            if (!ctrl[CTRL_ENDLESS])
              manual_trigger_key_left <= manual_trigger_key_left - 32'h0000_0001;
            if (!ctrl[CTRL_ENDLESS] && manual_trigger_key_left <= 32'h0000_0001)
              manual_trigger_key_left <= 32'h0000_0000;
          end
          else
            samples_left <= samples_left - 5'h01;
        end
      endcase
      // final scan pass returns first channel then idles
      // endless runs never end here, even with a zero pass count
      if (state == STS_CLOSE && scan_mode && !ctrl[CTRL_ENDLESS] &&
          manual_trigger_key_left == 32'h0000_0000)
        state <= STS_IDLE;
    end
  end
endmodule : sts_sequencer

// ===== sts_partner.sv
// partner: relay bank and measurement engine beside the sequencer
`timescale 1ns/1ps
module sts_partner #(
  parameter int ACK_DLY = 4,
  parameter int MEAS_DLY = 6
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic relay_close, // close request
  output logic relay_open_ack, // relays open
  input wire logic meas_start, // start pulse
  output logic meas_done // stored pulse
);
  int ack_cnt;
  int meas_cnt;
  // contacts take time to break, so the ack lags the release
  always_ff @(posedge aclk)
  begin
    if (!aresetn || relay_close)
    begin
      ack_cnt <= 0;
      relay_open_ack <= 1'b0;
    end
    else if (ack_cnt < ACK_DLY)
      ack_cnt <= ack_cnt + 1;
    else
      relay_open_ack <= 1'b1;
  end
  always_ff @(posedge aclk)
  begin
    meas_done <= aresetn && (meas_cnt == 1);
    if (!aresetn)
      meas_cnt <= 0;
    else if (meas_start)
      meas_cnt <= MEAS_DLY;
    else if (meas_cnt != 0)
      meas_cnt <= meas_cnt - 1;
  end
endmodule : sts_partner

// ===== sts_sequencer_assertions.sv
// checker: port properties of the scan trigger sequencer
`timescale 1ns/1ps
module sts_sequencer_assertions
  import sts_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axil_awvalid, // aw valid
  input wire logic s_axil_awready, // aw ready
  input wire logic s_axil_wvalid, // w valid
  input wire logic s_axil_wready, // w ready
  input wire logic s_axil_bvalid, // b valid
  input wire logic s_axil_arvalid, // ar valid
  input wire logic s_axil_arready, // ar ready
  input wire logic s_axil_rvalid, // r valid
  input wire logic trigger_out, // trigger pulse
  input wire logic [11:0] relay_close_id, // channel id
  input wire logic relay_close, // close level
  input wire logic relay_open_ack, // relays open
  input wire logic meas_start, // start pulse
  input wire logic meas_done // stored pulse
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  sequence s_relay_gap;
    !relay_close ##1 !relay_close;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##2 s_axil_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (s_axil_arvalid && s_axil_arready
    |=> s_axil_rvalid)
    else $error("read data missing");
  a_break_make: assert property (
    $rose(relay_close) |-> $past(relay_open_ack))
    else $error("relay closed before open confirmed");
  a_relay_gap: assert property ($fell(relay_close) |-> s_relay_gap)
    else $error("next channel closed too soon");
  a_id_steady: assert property (
    relay_close && $past(relay_close) |-> $stable(relay_close_id))
    else $error("channel id moved while closed");
  a_meas_closed: assert property (meas_start |-> relay_close)
    else $error("measurement with no channel closed");
  a_meas_single: assert property (meas_start |=> !meas_start [*3])
    else $error("measurement restarted early");
  a_manual_trigger_key_pulse: assert property (trigger_out |=> !trigger_out)
    else $error("output trigger longer than one cycle");
  a_manual_trigger_key_stored: assert property (
    trigger_out |-> $past(meas_done) || $past(meas_done, 2)
    || $past(meas_done, 3) || $past(meas_done, 4))
    else $error("output trigger without stored reading");
endmodule : sts_sequencer_assertions

bind sts_sequencer sts_sequencer_assertions i_chk (.*);

// ===== testbench.sv
// testbench: register, step, scan and timer runs of the sequencer
`timescale 1ns/1ps
module testbench;
  import sts_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ext_trigger_in = 1'b0;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
  logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
  logic [31:0] s_axil_wdata = 32'h0000_0000;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic [31:0] s_axil_rdata, rd;
  logic [1:0] s_axil_bresp, s_axil_rresp, rr;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
  logic s_axil_rvalid, trigger_out, relay_close, relay_open_ack;
  logic meas_start, meas_filter, meas_done, filt;
  logic [11:0] relay_close_id;
  int n_errors = 0;
  int check_count = 0;
  int n_meas = 0;
  int n_tout = 0;
  int base, tbase, n;
  int q_at[$];
  // zero manual settle keeps every step far below one tick
  localparam logic [31:0] C_IMM = 32'h0000_0020;
  localparam logic [31:0] C_EXT = 32'h0000_0030;
  localparam logic [31:0] C_TMR = 32'h0000_0028;

  sts_sequencer i_dut (.*);
  sts_partner i_far (.*);

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  always @(negedge aclk)
  begin
    if (meas_start === 1'b1)
      n_meas++;
    if (meas_start === 1'b1)
      filt = meas_filter;
    if (trigger_out === 1'b1)
      n_tout++;
    if (trigger_out === 1'b1)
      q_at.push_back(n_meas);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    logic ta, tw, tr;
    k = 0;
    tr = 1'b0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_araddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= wr;
    s_axil_wvalid <= wr;
    s_axil_bready <= wr;
    s_axil_arvalid <= !wr;
    s_axil_rready <= !wr;
    while (!tr && k < 100)
    begin
      @(negedge aclk);
      ta = wr ? s_axil_awready : s_axil_arready;
      tw = wr && s_axil_wready;
      tr = wr ? s_axil_bvalid : s_axil_rvalid;
      rd = s_axil_rdata;
      rr = wr ? s_axil_bresp : s_axil_rresp;
      k++;
      @(posedge aclk);
      if (ta && wr) s_axil_awvalid <= 1'b0;
      if (ta && !wr) s_axil_arvalid <= 1'b0;
      if (tw) s_axil_wvalid <= 1'b0;
      if (tr) s_axil_bready <= 1'b0;
      if (tr) s_axil_rready <= 1'b0;
    end
    if (!tr)
    begin
      n_errors++;
      $display("Error at %0t: bus answer %h expected %h", $time, tr, 1'b1);
    end
  endtask : axi

  task automatic wait_state(input logic [3:0] s);
    int k;
    k = 0;
    do
    begin
      axi(1'b0, ADDR_STATUS, 32'h0000_0000);
      k++;
    end
    while (rd[3:0] !== s && k < 5000);
    chk(rd[3:0], s);
  endtask : wait_state

  task automatic pulse_ext;
    @(posedge aclk);
    ext_trigger_in <= 1'b1;
    @(posedge aclk);
    ext_trigger_in <= 1'b0;
  endtask : pulse_ext

  task automatic t_regs;
    axi(1'b0, ADDR_AVG, 32'h0000_0000);
    chk(rd, 32'h0000_01F4);
    axi(1'b1, ADDR_TIMER, 32'hFFFF_FFFF);
    chk(rr, RESP_OKAY);
    axi(1'b0, ADDR_TIMER, 32'h0000_0000);
    chk(rd, 32'h3B9A_C9FF);
    axi(1'b1, ADDR_SETTLE, 32'hFFFF_FFFF);
    axi(1'b0, ADDR_SETTLE, 32'h0000_0000);
    chk(rd, 32'h159A_653F);
    axi(1'b1, 8'h3C, 32'h0000_0000);
    chk(rr, RESP_SLVERR);
    axi(1'b0, 8'h3C, 32'h0000_0000);
    chk({rd[29:0], rr}, {30'h0000_0000, RESP_SLVERR});
    axi(1'b1, ADDR_TIMER, 32'h0000_0000);
    axi(1'b1, ADDR_SETTLE, 32'h0000_0000);
    axi(1'b1, ADDR_LEN, 32'h0000_0003);
    axi(1'b1, ADDR_LIST, 32'h0000_0101);
    axi(1'b1, ADDR_LIST + 8'h04, 32'h0000_0102);
    axi(1'b1, ADDR_LIST + 8'h08, 32'h0000_0105);
    $display("test regs done");
  endtask : t_regs

  task automatic t_step;
    base = n_meas;
    tbase = n_tout;
    axi(1'b1, ADDR_COUNT, 32'h0000_0002);
    axi(1'b1, ADDR_CTRL, C_EXT | 32'h0000_0001);
    wait_state(STS_SOURCE);
    chk({relay_close, relay_close_id}, 32'h0000_1101);
    repeat (40) @(posedge aclk);
    chk(n_meas - base, 0);
    pulse_ext();
    wait_state(STS_SOURCE);
    chk({relay_close, relay_close_id}, 32'h0000_1102);
    chk(n_tout - tbase, 1);
    pulse_ext();
    wait_state(STS_IDLE);
    chk(n_meas - base, 2);
    chk({relay_close, relay_close_id}, 32'h0000_1102);
    axi(1'b1, ADDR_COUNT, 32'h0000_0001);
    axi(1'b1, ADDR_CTRL, C_EXT | 32'h0000_0001);
    wait_state(STS_SOURCE);
    chk({relay_close, relay_close_id}, 32'h0000_1105);
    pulse_ext();
    wait_state(STS_IDLE);
    $display("test step done");
  endtask : t_step

  task automatic t_scan;
    base = n_meas;
    axi(1'b1, ADDR_COUNT, 32'h0000_0004);
    axi(1'b1, ADDR_CTRL, C_IMM | 32'h0000_0082);
    wait_state(STS_IDLE);
    chk(n_meas - base, 6);
    chk(q_at[$ - 1] - base, 3);
    chk(q_at[$] - base, 6);
    chk({relay_close, relay_close_id}, 32'h0000_1101);
    chk(filt, 1'b1);
    base = n_meas;
    tbase = n_tout;
    axi(1'b1, ADDR_CTRL, C_EXT | 32'h0000_0002);
    wait_state(STS_SOURCE);
    chk(n_meas - base, 0);
    pulse_ext();
    wait_state(STS_SOURCE);
    chk(n_meas - base, 3);
    chk(n_tout - tbase, 1);
    axi(1'b1, ADDR_CTRL, C_EXT | 32'h0000_0200);
    wait_state(STS_IDLE);
    chk(n_meas - base, 6);
    chk(filt, 1'b0);
    $display("test scan done");
  endtask : t_scan

  task automatic t_more;
    base = n_meas;
    axi(1'b1, ADDR_CTRL, C_IMM | 32'h0000_0101);
    n = 0;
    while (n_meas - base < 6 && n < 20000)
    begin
      @(posedge aclk);
      n++;
    end
    axi(1'b1, ADDR_CTRL, C_IMM | 32'h0000_0004);
    wait_state(STS_IDLE);
    chk(n_meas - base > 5, 1'b1);
    axi(1'b1, ADDR_LEN, 32'h0000_0001);
    axi(1'b1, ADDR_COUNT, 32'h0000_0001);
    axi(1'b1, ADDR_TIMER, 32'h0000_0001);
    base = n_meas;
    axi(1'b1, ADDR_CTRL, C_TMR | 32'h0000_0002);
    // without the bypass the first reading waits for the next 1 ms tick
    repeat (500) @(posedge aclk);
    chk(n_meas - base, 1);
    wait_state(STS_IDLE);
    $display("test endless and timer done");
  endtask : t_more

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_step();
    t_scan();
    t_more();
    give_verdict();
  end

  initial
  begin
    repeat (50000) @(posedge aclk);
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule : testbench
